// ==== rtl/tsp_map.svh ====
/*
  Address map, field positions, reset values and timing constants of the
  timekeeping SRAM access port. Assumes inclusion by bare name.
*/
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH
// Clock register byte addresses
`define TSP_OFS_CTRL   11'h7F8
`define TSP_OFS_SEC    11'h7F9
`define TSP_OFS_MIN    11'h7FA
`define TSP_OFS_HOUR   11'h7FB
`define TSP_OFS_WDAY   11'h7FC
`define TSP_OFS_MDAY   11'h7FD
`define TSP_OFS_MONTH  11'h7FE
`define TSP_OFS_YEAR   11'h7FF
// Control and flag bit positions
`define TSP_BIT_SET_HOLD   7
`define TSP_BIT_SNAP_HOLD  6
`define TSP_BIT_OSC_HALT   7
`define TSP_BIT_RATE_PROBE 6
// Timekeeping bits of seconds to year; the rest, bar the halt and probe flags, are plain storage
`define TSP_MSK_SEC    8'h7F
`define TSP_MSK_MIN    8'h7F
`define TSP_MSK_HOUR   8'h3F
`define TSP_MSK_WDAY   8'h07
`define TSP_MSK_MDAY   8'h3F
`define TSP_MSK_MONTH  8'h1F
`define TSP_MSK_YEAR   8'hFF
// Counter reset values
`define TSP_RST_WDAY   8'h01
`define TSP_RST_MDAY   8'h01
`define TSP_RST_MONTH  8'h01
// Timing: system clock and internal tick rate (Hz)
`define TSP_CLK_HZ     20000000
`define TSP_TICK_HZ    1024
`define TSP_TICK_CYC   (`TSP_CLK_HZ / `TSP_TICK_HZ)
`endif

// ==== rtl/tsp_pkg.sv ====
/*
  Types of the timekeeping SRAM access port.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package tsp_pkg;
  typedef logic [7:0]            tsp_byte_t;
  // Index 0 seconds ... 6 year
  typedef tsp_byte_t [6:0]       tsp_time_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } tsp_acc_e;
endpackage : tsp_pkg
`default_nettype wire

// ==== rtl/tsp_ram.sv ====
/*
  Plain byte storage behind the access port.
  Assumes one write strobe per committed cycle, all inputs synchronous.
*/
`default_nettype none
module tsp_ram #(
  parameter int AW = 11
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_we,
  input  wire logic [AW-1:0]          i_waddr,
  input  wire tsp_pkg::tsp_byte_t     i_wdata,
  input  wire logic [AW-1:0]          i_raddr,
  output logic      [7:0]             o_rdata
);
  import tsp_pkg::*;
  // Contents survive reset, as in a battery-backed array
  tsp_byte_t mem [2**AW];

  // Write port
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Ripple-through read
  assign o_rdata = mem[i_raddr];
endmodule : tsp_ram
`default_nettype wire

// ==== rtl/tsp_bcd_counter.sv ====
/*
  Packed BCD calendar counters: seconds up to year, with month lengths and
  leap years. Assumes a one-cycle second pulse and a one-cycle load pulse.
*/
`include "tsp_map.svh"
`default_nettype none
module tsp_bcd_counter (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_tick,
  input  wire logic                i_load,
  input  wire tsp_pkg::tsp_time_t  i_load_val,
  output tsp_pkg::tsp_time_t       o_time
);
  import tsp_pkg::*;
  tsp_time_t time_r;
  tsp_time_t time_nxt;

  function automatic tsp_byte_t bcd_inc(input tsp_byte_t v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // Years divisible by four; good up to 2099
  function automatic logic is_leap(input tsp_byte_t y);
    is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                   : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
  endfunction : is_leap

  function automatic tsp_byte_t last_day(input tsp_byte_t m, input tsp_byte_t y);
    if (m == 8'h02) begin
      last_day = is_leap(y) ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      last_day = 8'h30;
    end else begin
      last_day = 8'h31;
    end
  endfunction : last_day

  // R21: BCD carry chain
  always_comb begin
    time_nxt = time_r;
    if (i_load) begin
      time_nxt = i_load_val;
    end else if (i_tick) begin
      time_nxt[0] = (time_r[0] == 8'h59) ? 8'h00 : bcd_inc(time_r[0]);
      if (time_r[0] == 8'h59) begin
        time_nxt[1] = (time_r[1] == 8'h59) ? 8'h00 : bcd_inc(time_r[1]);
        if (time_r[1] == 8'h59) begin
          time_nxt[2] = (time_r[2] == 8'h23) ? 8'h00 : bcd_inc(time_r[2]);
          if (time_r[2] == 8'h23) begin
            time_nxt[3] = (time_r[3] == 8'h07) ? `TSP_RST_WDAY : bcd_inc(time_r[3]);
            time_nxt[4] = (time_r[4] == last_day(time_r[5], time_r[6])) ? `TSP_RST_MDAY : bcd_inc(time_r[4]);
            if (time_r[4] == last_day(time_r[5], time_r[6])) begin
              time_nxt[5] = (time_r[5] == 8'h12) ? `TSP_RST_MONTH : bcd_inc(time_r[5]);
              if (time_r[5] == 8'h12) begin
                time_nxt[6] = (time_r[6] == 8'h99) ? 8'h00 : bcd_inc(time_r[6]);
              end
            end
          end
        end
      end
    end
  end

  // Counter state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      time_r <= {8'h00, `TSP_RST_MONTH, `TSP_RST_MDAY, `TSP_RST_WDAY, 8'h00, 8'h00, 8'h00};
    end else begin
      time_r <= time_nxt;
    end
  end

  assign o_time = time_r;
endmodule : tsp_bcd_counter
`default_nettype wire

// ==== rtl/tsp_port.sv ====
/*
  Bytewide access port of a timekeeping static RAM: plain storage below,
  eight clock registers at the top, hold bits, oscillator halt, rate probe,
  supply-fail blocking and backup arming.
  Assumes all pins synchronous to i_clk; the host keeps the bus timing.
*/
`include "tsp_map.svh"
`default_nettype none
// Operation
// R1: Top eight addresses 7F8 to 7FF are control then seconds to year.
// R2: Seconds bit 7 is the oscillator halt bit; seven bits hold seconds.
// R3: Control bit 7 is set-time hold, bit 6 snapshot hold.
// R4: Weekday bit 6 is the rate probe; weekday value in bits 2 to 0.
// R5: Unused clock register bits store host data like plain RAM.
// R6: Select active with store strobe high is a read; address alone changes it.
// R7: Data lines driven only while select and output drive are active.
// R8: Select and store strobe both active is a write, from the later edge.
// R9: Host holds address through the write and data valid around its end.
// R10: Host idles select or store strobe for recovery between accesses.
// R11: Output drive first shows read data, released once store strobe goes active.
// R12: Host keeps output drive off during writes or handles contention.
// R13: Supply fail blocks every access by forcing select inactive.
// R14: On backup power the clock keeps counting and contents stay unchanged.
// R15: Backup stays disconnected until supply first rises above the fail threshold.
// R16: No calibration register; the oscillator rate is fixed.
// R17: Snapshot hold freezes visible registers; all refresh together once cleared.
// R18: Set-time hold accepts writes; clearing loads them into the counters.
// R19: Writing one to oscillator halt stops timekeeping.
// R20: Rate probe with oscillator running toggles seconds LSB at 512 Hz.
// R21: Counters run in packed BCD with month lengths and leap years.
// R22: Address decode sends top eight locations to clock buffers, rest to storage.
module tsp_port #(
  parameter int TICK_CYC = `TSP_TICK_CYC,
  parameter int AW       = 11
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  input  wire logic [AW-1:0]       i_address_lines,
  input  wire logic                i_ce_n,
  input  wire logic                i_oe_n,
  input  wire logic                i_we_n,
  input  wire tsp_pkg::tsp_byte_t  i_data_lines,
  output tsp_pkg::tsp_byte_t       o_data_lines,
  output logic                     o_data_lines_oe,
  input  wire logic                i_supply_fail,
  input  wire logic                i_below_backup,
  output logic                     o_on_backup,
  output logic                     o_backup_armed
);
  import tsp_pkg::*;

  // Refuse settings the divider and decode cannot serve
  if (TICK_CYC < 2) begin : g_chk_tick
    $error("TICK_CYC must be at least 2");
  end
  if (AW < 4) begin : g_chk_aw
    $error("AW must be at least 4");
  end

  localparam int DW = $clog2(TICK_CYC);

  // Access decode state
  tsp_acc_e             st_r;
  tsp_acc_e             st_nxt;
  logic                 sel_eff;
  logic                 wr_req;
  logic                 rd_req;
  logic                 commit;
  logic [AW-1:0]        wr_addr_r;
  tsp_byte_t            wr_data_r;
  // Clock register buffers, index 0 control .. 7 year
  tsp_byte_t            vis_r [8];
  logic                 hit_rd;
  logic                 hit_wr;
  logic [2:0]           rd_idx;
  logic [2:0]           wr_idx;
  tsp_byte_t            ram_rd;
  tsp_byte_t            clk_rd;
  tsp_byte_t            rd_q_r;
  // Timekeeping
  logic [DW-1:0]        div_r;
  logic [9:0]           sub_r;
  logic                 tick_1k;
  logic                 tick_sec;
  logic                 probe_sq_r;
  logic                 osc_halt;
  logic                 rate_probe;
  logic                 set_hold;
  logic                 snap_hold;
  logic                 set_hold_fall;
  tsp_time_t            cnt;
  tsp_time_t            load_val;
  tsp_byte_t            msk [7];
  logic                 armed_r;

  assign msk = '{`TSP_MSK_SEC, `TSP_MSK_MIN, `TSP_MSK_HOUR, `TSP_MSK_WDAY,
                 `TSP_MSK_MDAY, `TSP_MSK_MONTH, `TSP_MSK_YEAR};

  // Clock location test and index within the top eight
  function automatic logic is_clk(input logic [AW-1:0] a);
    is_clk = (a[AW-1:3] == {(AW-3){1'b1}});
  endfunction : is_clk

  // R13: supply fail forces select inactive
  assign sel_eff = !i_ce_n && !i_supply_fail;
  // R8: write while select and store strobe both active
  assign wr_req  = sel_eff && !i_we_n;
  // R6: read while store strobe inactive
  assign rd_req  = sel_eff && i_we_n;

  // Access state follows the pins; a write starts at the later edge
  always_comb begin
    st_nxt = ST_IDLE;
    if (wr_req) begin
      st_nxt = ST_WRITE;
    end else if (rd_req) begin
      st_nxt = ST_READ;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // R9: address and data taken while the write stands, stored at its end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_addr_r <= '0;
      wr_data_r <= 8'h00;
    end else if (wr_req) begin
      wr_addr_r <= i_address_lines;
      wr_data_r <= i_data_lines;
    end
  end

  // R8: commit on the edge that ends the write; a failing supply aborts it
  // A write cut by supply fail is dropped whole, never half stored, so the
  // host finds either the old byte or the new one once power returns
  assign commit = (st_r == ST_WRITE) && !wr_req && !i_supply_fail;

  // R1: top eight locations are clock registers
  // R22: split between storage and clock buffers
  assign hit_rd = is_clk(i_address_lines);
  assign hit_wr = is_clk(wr_addr_r);
  assign rd_idx = i_address_lines[2:0];
  assign wr_idx = wr_addr_r[2:0];

  tsp_ram #(
    .AW      (AW)
  ) u_ram (
    .i_clk   (i_clk),
    .i_we    (commit && !hit_wr),
    .i_waddr (wr_addr_r),
    .i_wdata (wr_data_r),
    .i_raddr (i_address_lines),
    .o_rdata (ram_rd)
  );

  // R3: control hold bits
  assign set_hold   = vis_r[0][`TSP_BIT_SET_HOLD];
  assign snap_hold  = vis_r[0][`TSP_BIT_SNAP_HOLD];
  // R2: oscillator halt in seconds bit 7
  assign osc_halt   = vis_r[1][`TSP_BIT_OSC_HALT];
  // R4: rate probe in weekday bit 6
  assign rate_probe = vis_r[4][`TSP_BIT_RATE_PROBE];
  // Load only when a host write clears set-time hold; snapshot alone never loads
  assign set_hold_fall = set_hold && commit && hit_wr && (wr_idx == 3'h0)
                         && !wr_data_r[`TSP_BIT_SET_HOLD];

  // R19: halted oscillator stops the divider chain
  assign tick_1k  = !osc_halt && (div_r == DW'(TICK_CYC - 1));
  assign tick_sec = tick_1k && (sub_r == 10'h3FF);

  // R16: fixed-rate divider, no trim of any kind
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_r <= '0;
    end else if (!osc_halt) begin
      div_r <= tick_1k ? '0 : div_r + 1'b1;
    end
  end

  // Seconds prescaler and rate probe square wave
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sub_r      <= 10'h000;
      probe_sq_r <= 1'b0;
    end else if (tick_1k) begin
      sub_r      <= sub_r + 10'h001;
      // R20: one toggle per 1024 Hz tick gives 512 Hz
      probe_sq_r <= !probe_sq_r;
    end
  end

  // R18: counters take the visible timekeeping bits on release
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      load_val[i] = vis_r[i+1] & msk[i];
    end
  end

  // R14: counters run regardless of supply state
  tsp_bcd_counter u_cnt (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_tick     (tick_sec),
    .i_load     (set_hold_fall),
    .i_load_val (load_val),
    .o_time     (cnt)
  );

  // Visible buffers: host writes win, else refresh unless held
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 8; i++) begin
        vis_r[i] <= 8'h00;
      end
    end else begin
      for (int i = 1; i < 8; i++) begin
        // R17: both holds freeze the visible copy, counters keep running
        if (!set_hold && !snap_hold) begin
          // R5: unused bits keep host data
          vis_r[i] <= (vis_r[i] & ~msk[i-1]) | (cnt[i-1] & msk[i-1]);
        end
      end
      // R18: writes land in the buffers while held
      if (commit && hit_wr) begin
        vis_r[wr_idx] <= wr_data_r;
      end
    end
  end

  // R20: probe replaces the seconds LSB seen by a read
  always_comb begin
    clk_rd = vis_r[rd_idx];
    if (rd_idx == 3'h1 && rate_probe && !osc_halt) begin
      clk_rd[0] = probe_sq_r;
    end
  end

  // Read data follows the address each cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_q_r <= 8'h00;
    end else begin
      rd_q_r <= hit_rd ? clk_rd : ram_rd;
    end
  end

  assign o_data_lines = rd_q_r;
  // R7: drive only under select and output drive
  // R11: store strobe going active releases the lines
  assign o_data_lines_oe = rd_req && !i_oe_n;

  // R15: backup armed once supply first reads good
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      armed_r <= 1'b0;
    end else if (!i_supply_fail) begin
      armed_r <= 1'b1;
    end
  end

  assign o_backup_armed = armed_r;
  // R15: switch to backup only when armed
  assign o_on_backup    = armed_r && i_below_backup;

  // Checks
  a_drive_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
    o_data_lines_oe |-> (!i_ce_n && !i_oe_n && i_we_n && !i_supply_fail))
    else $error("data lines driven outside a read");

  a_fail_block: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
    i_supply_fail |-> (!o_data_lines_oe && !commit))
    else $error("access during supply fail");

  a_write_start: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
    wr_req |=> (st_r == ST_WRITE) && $past(i_data_lines) == wr_data_r)
    else $error("write not taken");

  a_read_ram: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R6
    (rd_req && !hit_rd && !commit) |=> (o_data_lines == $past(ram_rd)))
    else $error("read data wrong");

  // Clock reads come from the visible buffers, never from the live counters
  a_clk_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R22
    (rd_req && hit_rd) |=> (o_data_lines == $past(clk_rd)))
    else $error("clock read data wrong");

  a_fail_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
    i_supply_fail |=> (st_r == ST_IDLE))
    else $error("access state moved during supply fail");

  a_unused_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R5
    (commit && hit_wr && wr_idx == 3'h4) ##1 !(commit && hit_wr && wr_idx == 3'h4)
    |-> ((vis_r[4] & ~`TSP_MSK_WDAY) == ($past(wr_data_r) & ~`TSP_MSK_WDAY)))
    else $error("unused bits lost");

  a_snap_freeze: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
    (snap_hold && !commit) |=> $stable(vis_r[2]) && $stable(vis_r[3]))
    else $error("visible time moved while frozen");

  a_set_freeze: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
    (set_hold && !commit) |=> $stable(vis_r[1]) && $stable(vis_r[5]))
    else $error("visible time moved while setting");

  a_load_time: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R18
    set_hold_fall |=> (cnt == $past(load_val)))
    else $error("counters not loaded");

  // Divider holds from the edge after the halt bit is seen
  a_osc_halt: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R19
    osc_halt |-> !tick_sec ##1 $stable(div_r))
    else $error("oscillator ran while halted");

  a_probe_rate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R20
    tick_1k |=> (probe_sq_r != $past(probe_sq_r)) ##1 $stable(probe_sq_r))
    else $error("probe toggle wrong");

  a_probe_seen: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R20
    (rd_req && hit_rd && rd_idx == 3'h1 && rate_probe && !osc_halt)
    |=> (o_data_lines[0] == $past(probe_sq_r)))
    else $error("probe not on seconds read");

  a_backup_arm: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
    $rose(armed_r) |-> !$past(i_supply_fail))
    else $error("backup armed without good supply");

  // A lost arm would drop time and data on the next outage
  a_arm_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
    armed_r |=> armed_r)
    else $error("backup disarmed");

  // Scenarios the bench must reach
  c_ram_read: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_req && !i_oe_n && !hit_rd);
  c_clk_write: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    commit && hit_wr);
  c_time_load: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    set_hold_fall);
  c_probe_read: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_req && hit_rd && rd_idx == 3'h1 && rate_probe);
  c_fail_block: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    i_supply_fail && !i_ce_n);
endmodule : tsp_port
`default_nettype wire

// ==== dv/tsp_host_model.sv ====
/*
  Host bus model for the timekeeping access port: bytewide reads and writes
  with select, output drive and store strobe. Assumes one clock, and that
  its tasks are called from one process at a time.
*/
`default_nettype none
module tsp_host_model (
  input  wire logic        i_clk,
  output var  logic [10:0] o_addr,
  output var  logic        o_ce_n,
  output var  logic        o_oe_n,
  output var  logic        o_we_n,
  output var  logic [7:0]  o_data,
  output var  logic        o_rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idle at time zero
  initial begin
    o_addr = 11'h000;
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    o_we_n = 1'b1;
    o_data = 8'hA5;
    o_rd_valid = 1'b0;
  end

  // Start a read; returns at the edge that samples it
  task automatic rd_open(input logic [10:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_ce_n <= 1'b0;
    o_oe_n <= 1'b0;
    @(posedge i_clk);
  endtask : rd_open

  // idle edge before the next access
  task automatic rd_close();
    o_rd_valid <= 1'b0;
    o_ce_n <= 1'b1;
    o_oe_n <= 1'b1;
  endtask : rd_close

  // One read; valid pulse marks the cycle holding the result
  task automatic rd(input logic [10:0] a);
    rd_open(a);
    o_rd_valid <= 1'b1;
    @(posedge i_clk);
    rd_close();
  endtask : rd

  // write, address and data held; strobe order random
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic ov);
    logic ce_first;
    ce_first = 1'($urandom_range(0, 1));
    if (ov) begin
      rd_open(a);
      o_rd_valid <= 1'b1;
    end
    @(posedge i_clk);
    o_rd_valid <= 1'b0;
    o_addr <= a;
    o_data <= d;
    o_oe_n <= !ov;
    if (ce_first) o_ce_n <= 1'b0;
    else o_we_n <= 1'b0;
    @(posedge i_clk);
    o_ce_n <= 1'b0;
    o_we_n <= 1'b0;
    o_rd_valid <= ov;
    @(posedge i_clk);
    o_rd_valid <= 1'b0;
    if (ce_first) o_we_n <= 1'b1;
    else o_ce_n <= 1'b1;
    // both strobes off; released data shows no stale value
    @(posedge i_clk);
    o_ce_n <= 1'b1;
    o_we_n <= 1'b1;
    o_oe_n <= 1'b1;
    o_data <= ~d;
  endtask : wr
endmodule : tsp_host_model
`default_nettype wire

// ==== dv/tb_top.sv ====
/*
  Self-checking bench of the access port: storage, clock registers, hold
  bits, probe, supply fail and backup. Assumes the host model and design.
*/
`include "tsp_map.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tsp_pkg::*;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR at %0t: got %h expected %h", $time, g, e); end end

  typedef struct packed {
    tsp_byte_t data;
    tsp_byte_t mask;
    logic      oe;
  } tsp_exp_s;

  // Time bytes seconds to year, before and after crossing midnight
  localparam tsp_byte_t SET_T [7] = '{8'h58, 8'hD9, 8'hE3, 8'hBF, 8'hE8, 8'hE2, 8'h00};
  localparam tsp_byte_t NEW_T [7] = '{8'h00, 8'h80, 8'hC0, 8'hB9, 8'hE9, 8'hE2, 8'h00};

  logic        clk = 1'b0;
  logic        rst_n;
  logic        supply_fail;
  logic        below_backup;
  logic [10:0] addr;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  tsp_byte_t   wdata;
  logic        rd_valid;
  tsp_byte_t   rdata;
  logic        rdata_oe;
  logic        on_backup;
  logic        armed;
  tsp_exp_s    exp_q [$];
  tsp_exp_s    exp_e;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #25 clk = ~clk;

  tsp_host_model host (.i_clk(clk), .o_addr(addr), .o_ce_n(ce_n), .o_oe_n(oe_n),
                       .o_we_n(we_n), .o_data(wdata), .o_rd_valid(rd_valid));

  // Second tick shortened to 4096 clocks
  tsp_port #(.TICK_CYC(4), .AW(11)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_address_lines(addr), .i_ce_n(ce_n),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_data_lines(wdata), .o_data_lines(rdata),
    .o_data_lines_oe(rdata_oe), .i_supply_fail(supply_fail),
    .i_below_backup(below_backup), .o_on_backup(on_backup), .o_backup_armed(armed));

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Note the expected result, then read
  task automatic rd_exp(input logic [10:0] a, input tsp_byte_t d, input tsp_byte_t m, input logic oe);
    exp_q.push_back('{data: d, mask: m, oe: oe});
    host.rd(a);
  endtask : rd_exp

  // Results taken off the queue as they appear
  always @(negedge clk) begin
    if (rd_valid === 1'b1) begin
      exp_e = exp_q.pop_front();
      `CHK(rdata & exp_e.mask, exp_e.data & exp_e.mask)
      `CHK(rdata_oe, exp_e.oe)
    end
  end

  // Runs are about 20000 cycles; a hang ends well past that
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin : main
    logic [10:0] addrs [8];
    tsp_byte_t   datas [8];
    int          toggles;
    logic        prev;
    void'($urandom(90));
    rst_n = 1'b0;
    supply_fail = 1'b1;
    below_backup = 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    // backup not armed before supply first good
    `CHK(armed, 1'b0)
    `CHK(on_backup, 1'b0)
    @(posedge clk);
    supply_fail <= 1'b0;
    below_backup <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    `CHK(armed, 1'b1)
    // storage spread over the whole lower range, boundaries included
    foreach (addrs[i]) begin
      addrs[i] = 11'(i * 255 + $urandom_range(0, 254));
      datas[i] = 8'($urandom());
    end
    addrs[0] = 11'h000;
    addrs[7] = 11'h7F7;
    foreach (addrs[i]) host.wr(addrs[i], datas[i], 1'b0);
    for (int i = 7; i >= 0; i--) rd_exp(addrs[i], datas[i], 8'hFF, 1'b1);
    // output drive held low across the falling store strobe
    exp_q.push_back('{data: datas[1], mask: 8'hFF, oe: 1'b1});
    exp_q.push_back('{data: 8'h00, mask: 8'h00, oe: 1'b0});
    host.wr(addrs[1], 8'h5A, 1'b1);
    rd_exp(addrs[1], 8'h5A, 8'hFF, 1'b1);
    // supply fail blocks access; contents kept on backup
    @(posedge clk);
    supply_fail <= 1'b1;
    below_backup <= 1'b1;
    @(negedge clk);
    `CHK(on_backup, 1'b1)
    host.wr(addrs[0], ~datas[0], 1'b0);
    rd_exp(addrs[0], 8'h00, 8'h00, 1'b0);
    @(posedge clk);
    supply_fail <= 1'b0;
    below_backup <= 1'b0;
    rd_exp(addrs[0], datas[0], 8'hFF, 1'b1);
    // set time just before a leap day midnight
    host.wr(`TSP_OFS_CTRL, 8'h80, 1'b0);
    foreach (SET_T[i]) host.wr(`TSP_OFS_SEC + 11'(i), SET_T[i], 1'b0);
    rd_exp(`TSP_OFS_MIN, 8'hD9, 8'hFF, 1'b1);
    host.wr(`TSP_OFS_CTRL, 8'h15, 1'b0);
    repeat (10240) @(posedge clk);
    // snapshot, then rolled fields with unused bits kept
    host.wr(`TSP_OFS_CTRL, 8'h55, 1'b0);
    rd_exp(`TSP_OFS_SEC, NEW_T[0], 8'h7E, 1'b1);
    for (int i = 1; i < 7; i++) rd_exp(`TSP_OFS_SEC + 11'(i), NEW_T[i], 8'hFF, 1'b1);
    rd_exp(`TSP_OFS_CTRL, 8'h55, 8'hFF, 1'b1);
    host.wr(`TSP_OFS_CTRL, 8'h80, 1'b0);
    host.wr(`TSP_OFS_SEC, 8'h80, 1'b0);
    host.wr(`TSP_OFS_CTRL, 8'h00, 1'b0);
    repeat (8192) @(posedge clk);
    rd_exp(`TSP_OFS_SEC, 8'h80, 8'hFF, 1'b1);
    // probe: seconds bit 0 toggles every tick of 4 clocks
    host.wr(`TSP_OFS_CTRL, 8'h80, 1'b0);
    host.wr(`TSP_OFS_SEC, 8'h00, 1'b0);
    host.wr(`TSP_OFS_WDAY, 8'h41, 1'b0);
    host.wr(`TSP_OFS_CTRL, 8'h00, 1'b0);
    host.rd_open(`TSP_OFS_SEC);
    @(negedge clk);
    prev = rdata[0];
    toggles = 0;
    repeat (64) begin
      @(negedge clk);
      if (rdata[0] !== prev) toggles++;
      prev = rdata[0];
    end
    `CHK(toggles, 16)
    @(posedge clk);
    host.rd_close();
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
